/* File: inc/sia_pkg.sv */
// Package: register map, field layouts and encodings of the sync input alignment block
package sia_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] SIA_CTRL_BASE = 8'h00;
    localparam logic [7:0] SIA_STAT_BASE = 8'h08;
    localparam logic [7:0] SIA_INCFG_BASE = 8'h40;

    // ==========================================================
    // Reset values and writable masks
    localparam logic [31:0] SIA_CTRL_RST = 32'h0001_0000;
    localparam logic [31:0] SIA_INCFG_RST = 32'h0000_0000;
    localparam logic [31:0] SIA_CTRL_WMASK = 32'hffff_0f1f;
    localparam logic [31:0] SIA_INCFG_WMASK = 32'h0001_ff3f;

    // ==========================================================
    // AXI responses
    localparam logic [1:0] SIA_RESP_OKAY = 2'h0;
    localparam logic [1:0] SIA_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Encodings
    typedef enum logic [1:0] {
        PH_ON_TARGET,
        PH_HALF_EARLY,
        PH_HALF_LATE,
        PH_ONE_LATE
    } sia_phase_e;

    typedef enum logic [1:0] {
        FQ_1PPS,
        FQ_2K,
        FQ_4K,
        FQ_8K
    } sia_freq_e;

    typedef enum logic [2:0] {
        SMP_IDLE,
        SMP_RISE,
        SMP_FALL,
        SMP_RISE_RISE,
        SMP_RISE_FALL
    } sia_samp_e;

    // Per-DPLL control word, bit 0 first from the bottom
    typedef struct packed {
        logic [7:0] skew;
        logic [7:0] div;
        logic [3:0] rsv1;
        logic [3:0] ref_idx;
        logic [2:0] rsv0;
        logic frac;
        logic edge_rise;
        sia_freq_e freq;
        logic en;
    } sia_dpll_cfg_s;

    // Per-input configuration word
    typedef struct packed {
        logic [14:0] rsv1;
        logic is_sync;
        logic [1:0][3:0] prio;
        logic [1:0] rsv0;
        sia_phase_e phase;
        logic [3:0] sel;
    } sia_in_cfg_s;

endpackage

/* File: rtl/sia_sync_align.sv */
// Sync input alignment: pin capture, sampling phase, fractional divider resync, skew, frame pulses
//
// Notes on behaviour
// RULE_01 - Any input may be a sync input; four-bit field picks its reference.
// RULE_02 - Per-DPLL external pulse enable, reset off; no sync processing while off.
// RULE_03 - Source sends all sync inputs at one frequency matching the frequency field.
// RULE_04 - Priority field zero removes that input from automatic reference selection.
// RULE_05 - Falling sync edge aligns by default; edge bit set selects rising edge.
// RULE_06 - Sync phase accepted from half UI early to one UI late.
// RULE_07 - Slower synchronous output clocks need software re-alignment at lock or holdover exit.
// RULE_08 - Sampled sync input drives the frame and multiframe pulse outputs.
// RULE_09 - Per-input phase field: on target, half early, half late, one UI late.
// RULE_10 - Source keeps the sync edge inside one UI minus 6 ns window.
// RULE_11 - Sync input resynchronises the fractional divider to a fixed reference cycle.
// RULE_12 - Software selects rising-edge alignment whenever the fractional divider is used.
// RULE_13 - Divider resync lands on the next undivided reference cycle: one period offset.
// RULE_14 - Skew adjustment sits after the phase detector, shifting pulse outputs too.
// RULE_15 - With fractional divider the pulse looks early; half early offset is advised.
// RULE_16 - On target or one late for sync pulses; half offsets for framing pulses.
// RULE_17 - Regenerated pulse aligns to first reference edge after the sync edge.
// RULE_18 - Sync captured in reference timing; one-cycle alignment event per qualifying edge.
//
// Our own choices: the address map and the AXI4-Lite slave port.
module sia_sync_align
    import sia_pkg::*;
#(
    parameter int N_IN = 14,
    parameter int N_DPLL = 2
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Clock input pins, any of which may carry a sync pulse
    input wire logic [N_IN-1:0] clock_input_pin,
    // Per-DPLL results
    output logic [N_DPLL-1:0] align_event,
    output logic [N_DPLL-1:0] frame_pulse_output,
    output logic [N_DPLL-1:0] multiframe_pulse_output,
    output logic [N_DPLL-1:0] divided_ref_tick,
    output logic [N_DPLL*N_IN-1:0] ref_eligible
);

    // ==========================================================
    // Helpers
    function automatic logic [7:0] reg_addr(input logic [7:0] base, input int idx);
        reg_addr = base + 8'(idx * 4);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old & ~m) | (wd & m);
    endfunction

    // Out-of-range index reads as low instead of X
    function automatic logic pick(input logic [N_IN-1:0] v, input logic [3:0] idx);
        pick = (32'(idx) < N_IN) ? v[idx] : 1'b0;
    endfunction

    // Frames per multiframe, minus one
    function automatic logic [1:0] mf_last(input sia_freq_e f);
        case (f)
            FQ_8K: mf_last = 2'h3;
            FQ_4K: mf_last = 2'h1;
            default: mf_last = 2'h0;
        endcase
    endfunction

    // ==========================================================
    // Register storage
    logic [31:0] ctrl_reg [N_DPLL];
    logic [31:0] incfg_reg [N_IN];
    logic [31:0] stat_w [N_DPLL];
    sia_in_cfg_s ic [N_IN];

    always_comb begin
        for (int i = 0; i < N_IN; i++) begin
            ic[i] = sia_in_cfg_s'(incfg_reg[i]);
        end
    end

    // ==========================================================
    // Pin synchronisers
    logic [N_IN-1:0] pin_meta_reg;
    logic [N_IN-1:0] pin_sync_reg;
    logic [N_IN-1:0] pin_last_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            pin_last_reg <= '0;
        end else begin
            pin_meta_reg <= clock_input_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    // ==========================================================
    // AXI4-Lite write path
    logic wr_hit;

    always_comb begin
        wr_hit = 1'b0;
        for (int d = 0; d < N_DPLL; d++) begin
            if (s_axi_awaddr == reg_addr(SIA_CTRL_BASE, d)) begin
                wr_hit = 1'b1;
            end
        end
        for (int i = 0; i < N_IN; i++) begin
            if (s_axi_awaddr == reg_addr(SIA_INCFG_BASE, i)) begin
                wr_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SIA_RESP_OKAY;
        end else begin
            // Both channels taken together, one cycle after both are offered
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? SIA_RESP_OKAY : SIA_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int d = 0; d < N_DPLL; d++) begin
                ctrl_reg[d] <= SIA_CTRL_RST; // RULE_02
            end
            for (int i = 0; i < N_IN; i++) begin
                incfg_reg[i] <= SIA_INCFG_RST;
            end
        end else if (s_axi_awready) begin
            for (int d = 0; d < N_DPLL; d++) begin
                if (s_axi_awaddr == reg_addr(SIA_CTRL_BASE, d)) begin
                    ctrl_reg[d] <= merge(ctrl_reg[d], s_axi_wdata, s_axi_wstrb, SIA_CTRL_WMASK);
                end
            end
            for (int i = 0; i < N_IN; i++) begin
                if (s_axi_awaddr == reg_addr(SIA_INCFG_BASE, i)) begin
                    incfg_reg[i] <= merge(incfg_reg[i], s_axi_wdata, s_axi_wstrb,
                                          SIA_INCFG_WMASK); // RULE_01
                end
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read path
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b0;
        for (int d = 0; d < N_DPLL; d++) begin
            if (s_axi_araddr == reg_addr(SIA_CTRL_BASE, d)) begin
                rd_word = ctrl_reg[d];
                rd_hit = 1'b1;
            end
            if (s_axi_araddr == reg_addr(SIA_STAT_BASE, d)) begin
                rd_word = stat_w[d];
                rd_hit = 1'b1;
            end
        end
        for (int i = 0; i < N_IN; i++) begin
            if (s_axi_araddr == reg_addr(SIA_INCFG_BASE, i)) begin
                rd_word = incfg_reg[i];
                rd_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= SIA_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? SIA_RESP_OKAY : SIA_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Per-DPLL alignment path
    for (genvar d = 0; d < N_DPLL; d++) begin : g_dpll
        sia_dpll_cfg_s c;
        logic [3:0] sidx;
        logic sfound;
        logic ref_rise;
        logic ref_fall;
        logic sync_edge;
        logic samp_rise;
        logic samp_fall;
        logic fire;
        logic emit;
        sia_samp_e st_reg;
        sia_samp_e st_next;
        logic [7:0] div_cnt_reg;
        logic dtick_reg;
        logic resync_reg;
        logic [7:0] skew_cnt_reg;
        logic frame_reg;
        logic mframe_reg;
        logic [1:0] mf_cnt_reg;
        logic ev_reg;
        logic [15:0] ev_cnt_reg;
        logic [N_IN-1:0] elig_reg;

        assign c = sia_dpll_cfg_s'(ctrl_reg[d]);

        // Lowest-numbered sync input tied to this DPLL's reference
        always_comb begin
            sfound = 1'b0;
            sidx = 4'h0;
            for (int i = N_IN - 1; i >= 0; i--) begin
                if (ic[i].is_sync && ic[i].sel == c.ref_idx) begin // RULE_01
                    sfound = 1'b1;
                    sidx = 4'(i);
                end
            end
        end

        assign ref_rise = pick(pin_sync_reg, c.ref_idx) && !pick(pin_last_reg, c.ref_idx);
        assign ref_fall = !pick(pin_sync_reg, c.ref_idx) && pick(pin_last_reg, c.ref_idx);
        assign sync_edge = sfound && c.en && (c.edge_rise ? // RULE_02
            (pick(pin_sync_reg, sidx) && !pick(pin_last_reg, sidx)) :
            (!pick(pin_sync_reg, sidx) && pick(pin_last_reg, sidx))); // RULE_05
        // Divided reference has no usable falling edge, so both phases sample on its tick
        assign samp_rise = c.frac ? dtick_reg : ref_rise;
        assign samp_fall = c.frac ? dtick_reg : ref_fall;

        // Sampling phase: which reference edge after the sync edge takes it
        always_comb begin
            st_next = st_reg;
            fire = 1'b0;
            case (st_reg)
                SMP_IDLE: begin
                    if (sync_edge) begin
                        case (ic[sidx].phase) // RULE_09
                            PH_ON_TARGET: st_next = SMP_RISE;
                            PH_HALF_EARLY: st_next = SMP_FALL;
                            PH_HALF_LATE: st_next = SMP_RISE_FALL;
                            default: st_next = SMP_RISE_RISE; // RULE_06
                        endcase
                    end
                end
                SMP_RISE: begin
                    if (samp_rise) begin
                        fire = 1'b1; // RULE_17
                        st_next = SMP_IDLE;
                    end
                end
                SMP_FALL: begin
                    if (samp_fall) begin
                        fire = 1'b1;
                        st_next = SMP_IDLE;
                    end
                end
                SMP_RISE_RISE: begin
                    if (samp_rise) begin
                        st_next = SMP_RISE;
                    end
                end
                SMP_RISE_FALL: begin
                    if (samp_rise) begin
                        st_next = SMP_FALL;
                    end
                end
                default: st_next = SMP_IDLE;
            endcase
            if (!c.en) begin
                st_next = SMP_IDLE;
                fire = 1'b0;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                st_reg <= SMP_IDLE;
            end else begin
                st_reg <= st_next;
            end
        end

        // Fractional divider, restarted by the sync edge on the next reference cycle
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                div_cnt_reg <= 8'h00;
                dtick_reg <= 1'b0;
                resync_reg <= 1'b0;
            end else begin
                dtick_reg <= 1'b0;
                if (ref_rise) begin
                    if (resync_reg || ({1'b0, div_cnt_reg} + 9'h001 >= {1'b0, c.div})) begin
                        div_cnt_reg <= 8'h00; // RULE_13
                        dtick_reg <= 1'b1;
                    end else begin
                        div_cnt_reg <= div_cnt_reg + 8'h01;
                    end
                    resync_reg <= sync_edge && c.frac; // RULE_11
                end else if (sync_edge && c.frac) begin
                    resync_reg <= 1'b1; // RULE_11
                end
            end
        end

        // Skew delay sits behind the sampling point and moves the pulse outputs
        assign emit = (fire && c.skew == 8'h00) || (!fire && skew_cnt_reg == 8'h01);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                skew_cnt_reg <= 8'h00;
            end else if (fire) begin
                skew_cnt_reg <= c.skew; // RULE_14
            end else if (skew_cnt_reg != 8'h00) begin
                skew_cnt_reg <= skew_cnt_reg - 8'h01;
            end
        end

        // Frame and multiframe pulses regenerated from the sampled sync input
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                frame_reg <= 1'b0;
                mframe_reg <= 1'b0;
                mf_cnt_reg <= 2'h0;
            end else begin
                frame_reg <= emit; // RULE_08
                mframe_reg <= emit && mf_cnt_reg == 2'h0; // RULE_08
                if (emit) begin
                    mf_cnt_reg <= (mf_cnt_reg >= mf_last(c.freq)) ? 2'h0 : mf_cnt_reg + 2'h1;
                end
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ev_reg <= 1'b0;
                ev_cnt_reg <= 16'h0000;
            end else begin
                ev_reg <= fire; // RULE_18
                if (fire) begin
                    ev_cnt_reg <= ev_cnt_reg + 16'h0001;
                end
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                elig_reg <= '0;
            end else begin
                for (int i = 0; i < N_IN; i++) begin
                    elig_reg[i] <= ic[i].prio[d] != 4'h0; // RULE_04
                end
            end
        end

        assign stat_w[d] = {14'h0000, resync_reg, st_reg != SMP_IDLE, ev_cnt_reg};
        assign align_event[d] = ev_reg;
        assign frame_pulse_output[d] = frame_reg;
        assign multiframe_pulse_output[d] = mframe_reg;
        assign divided_ref_tick[d] = dtick_reg;
        assign ref_eligible[d*N_IN +: N_IN] = elig_reg;
    end

endmodule

/* File: tb/sia_sync_align_chk.sv */
// Checker: bus handshake timing and pulse relations of the alignment block
module sia_sync_align_chk
    import sia_pkg::*;
#(
    parameter int N_IN = 14,
    parameter int N_DPLL = 2
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pulse outputs
    input wire logic [N_DPLL-1:0] align_event,
    input wire logic [N_DPLL-1:0] frame_pulse_output,
    input wire logic [N_DPLL-1:0] multiframe_pulse_output,
    input wire logic [N_DPLL-1:0] divided_ref_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Shadow of the enable bit of the first DPLL
    logic en_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_reg <= 1'b0;
        end else if (s_axi_awready && s_axi_awaddr == SIA_CTRL_BASE && s_axi_wstrb[0]) begin
            en_reg <= s_axi_wdata[0];
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_answer;
        s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
    endsequence
    sequence rd_answer;
        s_axi_arready ##1 s_axi_rvalid;
    endsequence
    wr_latency_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid |=> wr_answer) else $error("write answer off time");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    rd_latency_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> rd_answer) else $error("read answer off time");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    event_pulse_a: assert property (align_event[0] |=> !align_event[0])
        else $error("alignment event too long");
    event_enable_a: assert property (!en_reg && !$past(en_reg) && !$past(en_reg, 2)
        |-> !align_event[0]) else $error("alignment event while disabled");
    frame_pulse_a: assert property (frame_pulse_output[0] |=> !frame_pulse_output[0])
        else $error("frame pulse too long");
    multi_in_frame_a: assert property (multiframe_pulse_output[0] |-> frame_pulse_output[0])
        else $error("multiframe pulse outside a frame");
    tick_pulse_a: assert property (divided_ref_tick[0] |=> !divided_ref_tick[0])
        else $error("divided tick too long");
endmodule

bind sia_sync_align sia_sync_align_chk #(.N_IN(N_IN), .N_DPLL(N_DPLL)) u_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .align_event, .frame_pulse_output, .multiframe_pulse_output, .divided_ref_tick
);

/* File: tb/sia_timing_src.sv */
// Upstream timing source: free reference on pin 0, sync pulses on pin 1
module sia_timing_src #(
    parameter int N_IN = 14,
    parameter int PERIOD_NS = 42
) (
    // Clock input pins
    output logic [N_IN-1:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk;
    logic sync_line;
    // Unused pins sit low like inputs with a pull-down
    assign pins = {{(N_IN-2){1'b0}}, sync_line, ref_clk};
    // A reference is a clock and runs free, unrelated to aclk
    initial begin
        ref_clk = 1'b0;
        forever #(PERIOD_NS / 2) ref_clk = ~ref_clk;
    end
    initial sync_line = 1'b0;
    // Both edges land a quarter period after a reference rise: inside the window
    task automatic send_pulse(input int width_ns);
        @(posedge ref_clk);
        #(PERIOD_NS / 4);
        sync_line = 1'b1;
        #(width_ns);
        sync_line = 1'b0;
        #(4 * PERIOD_NS);
    endtask
endmodule

/* File: tb/test_sia_sync_align.sv */
// Testbench: register access and sync pulse scenarios of the alignment block
module test_sia_sync_align
    import sia_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P = 42;
    localparam int W = 4 * P;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sync_q;
    logic [13:0] pins;
    logic [1:0] evt, frm, mfrm, tick;
    logic [27:0] elig;
    int n_fail = 0, total_checks = 0, cyc = 0, n_evt = 0, n_evt1 = 0, n_frm = 0, n_mf = 0;
    int n_tick = 0, t_evt = 0, t_frm = 0, t_sync = 0, tick_lat = 0, m0;
    int lat[4];
    int mf_exp[4] = '{8, 8, 4, 2};
    bit armed = 0;

    sia_sync_align dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_input_pin(pins),
        .align_event(evt), .frame_pulse_output(frm), .multiframe_pulse_output(mfrm),
        .divided_ref_tick(tick), .ref_eligible(elig)
    );
    sia_timing_src #(.N_IN(14), .PERIOD_NS(P)) src (.pins(pins));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ==========================================================
    // Pulse monitor
    always @(posedge aclk) begin
        cyc++;
        if (pins[1] === 1'b1 && sync_q !== 1'b1) begin
            t_sync = cyc;
            armed = 1;
        end
        sync_q = pins[1];
        if (evt[0] === 1'b1) begin
            n_evt++;
            t_evt = cyc;
        end
        if (evt[1] === 1'b1 || frm[1] === 1'b1 || mfrm[1] === 1'b1) n_evt1++;
        if (frm[0] === 1'b1) begin
            n_frm++;
            t_frm = cyc;
        end
        if (mfrm[0] === 1'b1) n_mf++;
        if (tick[0] === 1'b1 && armed && cyc - t_sync > 2) begin
            tick_lat = cyc - t_sync;
            armed = 0;
        end
        if (tick[0] === 1'b1) n_tick++;
    end
    // ==========================================================
    // Compare, bus and closing tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_true(input logic ok);
        chk_word({31'h0, ok}, 32'h1);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk_word({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk_word(s_axi_rdata, ed);
        chk_word({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Bounds a hang; the full sequence needs about 17 us
    initial begin
        #100us;
        n_fail++;
        $display("mismatch at %0t: timeout", $time);
        end_of_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(SIA_CTRL_BASE, SIA_CTRL_RST, SIA_RESP_OKAY);
        axi_rd(SIA_INCFG_BASE + 8'h04, SIA_INCFG_RST, SIA_RESP_OKAY);
        chk_word({4'h0, elig}, 32'h0);
        axi_rd(8'h20, 32'h0, SIA_RESP_SLVERR);
        axi_wr(8'h20, 32'hffff_ffff, SIA_RESP_SLVERR);
        axi_wr(SIA_INCFG_BASE + 8'h04, 32'hffff_ffff, SIA_RESP_OKAY);
        axi_rd(SIA_INCFG_BASE + 8'h04, SIA_INCFG_WMASK, SIA_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk_word({4'h0, elig}, 32'h0000_8002);
        axi_wr(SIA_INCFG_BASE, 32'h0000_0500, SIA_RESP_OKAY);
        axi_wr(SIA_INCFG_BASE + 8'h04, 32'h0001_0000, SIA_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk_word({4'h0, elig}, 32'h1);
        src.send_pulse(W);
        chk_word(n_evt, 0);
        axi_wr(SIA_CTRL_BASE, 32'h0001_0001, SIA_RESP_OKAY);
        for (int p = 0; p < 4; p++) begin
            axi_wr(SIA_INCFG_BASE + 8'h04, 32'h0001_0000 | (p << 4), SIA_RESP_OKAY);
            src.send_pulse(W);
            lat[p] = t_evt - t_sync;
            chk_word(n_evt, p + 1);
        end
        chk_word(n_frm, 4);
        chk_true(lat[0] > W / 5);
        chk_true(lat[0] - W / 5 <= P / 5 + 3);
        chk_true(lat[1] < lat[0]);
        chk_true(lat[0] < lat[2]);
        chk_true(lat[2] < lat[3]);
        axi_wr(SIA_INCFG_BASE + 8'h04, 32'h0001_0000, SIA_RESP_OKAY);
        axi_wr(SIA_CTRL_BASE, 32'h0001_0009, SIA_RESP_OKAY);
        src.send_pulse(W);
        chk_true(t_evt - t_sync < W / 5);
        axi_wr(SIA_CTRL_BASE, 32'h0a01_0009, SIA_RESP_OKAY);
        src.send_pulse(W);
        chk_word(t_frm - t_evt, 10);
        for (int f = 0; f < 4; f++) begin
            axi_wr(SIA_CTRL_BASE, 32'h0001_0009 | (f << 1), SIA_RESP_OKAY);
            m0 = n_mf;
            repeat (8) src.send_pulse(W);
            chk_word(n_mf - m0, mf_exp[f]);
        end
        chk_word(n_evt1, 0);
        axi_wr(SIA_INCFG_BASE + 8'h04, 32'h0001_0010, SIA_RESP_OKAY);
        axi_wr(SIA_CTRL_BASE, 32'h0003_0019, SIA_RESP_OKAY);
        m0 = n_tick;
        #(30 * P);
        chk_true(n_tick - m0 >= 9 && n_tick - m0 <= 11);
        m0 = n_evt;
        src.send_pulse(W);
        chk_true(tick_lat >= 5 && tick_lat <= 13);
        chk_word(n_evt - m0, 1);
        axi_rd(SIA_STAT_BASE, 32'h27, SIA_RESP_OKAY);
        end_of_test();
    end
endmodule
